// ==== rtl/mmc_regs.svh ====
// Register offsets, field positions, reset values and timing counts.
`ifndef MMC_REGS_SVH
`define MMC_REGS_SVH

// Register indices; the byte address is four times the index.
`define MMC_IDX_MISC       8'h75
`define MMC_IDX_BLK0       8'h79
`define MMC_IDX_BLK1       8'h7a
`define MMC_IDX_BLK2       8'h7b
`define MMC_IDX_BLK3       8'h7c
`define MMC_IDX_IRQ_STATUS 8'h80
`define MMC_IDX_IRQ_CLEAR  8'h81
`define MMC_IDX_IRQ_ENABLE 8'h82

// Control word field positions.
`define MMC_WAVE_CNT_LSB   16
`define MMC_WAVE_CNT_MSB   24
`define MMC_BIT_CK_GATE    4
`define MMC_BIT_PD_GATE    3
`define MMC_BIT_IRQ_POL    2
`define MMC_BIT_BURST_CTL  1
`define MMC_BIT_BAUD_ADAPT 0
`define MMC_MISC_WMASK     32'h0000001f

// Interrupt status bit positions.
`define MMC_IRQ_CHECKSUM   0
`define MMC_IRQ_SUPPLY_LOW 1
`define MMC_IRQ_BLOCK_DONE 2
`define MMC_IRQ_BITS       3

// Reset values.
`define MMC_MISC_RESET     32'h00000000
`define MMC_BLK_RESET      32'h00000000
`define MMC_IRQ_RESET      3'h0

// Block read geometry and read latency of the internal register port.
`define MMC_SLOT_COUNT     16
`define MMC_RD_LATENCY     1

`endif

// ==== rtl/mmc_pkg.sv ====
// Types shared by the control and block read logic.
package mmc_pkg;

  typedef enum logic [1:0] {
    MMC_IDLE,
    MMC_FETCH,
    MMC_WAIT,
    MMC_HOLD
  } mmc_blk_state_e;

  typedef logic [7:0] mmc_slot_t;

endpackage

// ==== rtl/mmc_block_reader.sv ====
// Sequencer that reads the registers named by the sixteen address slots.
`timescale 1ns/1ps
`include "mmc_regs.svh"

module mmc_block_reader
  import mmc_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         start,
  input  wire logic [127:0] slots,
  output logic [7:0]        rdAddr,
  output logic              rdStrobe,
  input  wire logic [31:0]  rdData,
  output logic [31:0]       outData,
  output logic [3:0]        outIndex,
  output logic              outValid,
  input  wire logic         outReady,
  output logic              busy,
  output logic              done
);

  mmc_blk_state_e state;
  logic [3:0]     slotIdx;

  // Picks one 8-bit slot out of the packed slot vector.
  function automatic mmc_slot_t slotOf(input logic [127:0] v,
                                       input logic [3:0]   i);
    slotOf = v[{i, 3'h0} +: 8];
  endfunction

  // Walks the slots in order from slot zero, one register per slot.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state    <= MMC_IDLE;
      slotIdx  <= 4'h0;
      rdAddr   <= 8'h00;
      rdStrobe <= 1'b0;
      outData  <= 32'h00000000;
      outIndex <= 4'h0;
      outValid <= 1'b0;
      done     <= 1'b0;
    end else begin
      rdStrobe <= 1'b0;
      done     <= 1'b0;
      case (state)
        MMC_IDLE: begin
          if (start) begin
            slotIdx  <= 4'h0;
            rdAddr   <= slotOf(slots, 4'h0);
            rdStrobe <= 1'b1;
            state    <= MMC_FETCH;
          end
        end
        MMC_FETCH: begin
          state <= MMC_WAIT;
        end
        MMC_WAIT: begin
          outData  <= rdData;
          outIndex <= slotIdx;
          outValid <= 1'b1;
          state    <= MMC_HOLD;
        end
        MMC_HOLD: begin
          // The consumer may stall; the word stands until it is taken.
          if (outReady) begin
            outValid <= 1'b0;
            if (slotIdx == 4'hf) begin
              done  <= 1'b1;
              state <= MMC_IDLE;
            end else begin
              slotIdx  <= slotIdx + 4'h1;
              rdAddr   <= slotOf(slots, slotIdx + 4'h1);
              rdStrobe <= 1'b1;
              state    <= MMC_FETCH;
            end
          end
        end
        default: begin
          state <= MMC_IDLE;
        end
      endcase
    end
  end

  assign busy = (state != MMC_IDLE);

endmodule

// ==== rtl/mmc_misc_control.sv ====
// Miscellaneous system control word, block read slots and their bus slave.
`timescale 1ns/1ps
`include "mmc_regs.svh"

// What this block does
// - Nine-bit read-only waveform storage count, zero after reset.
// - Checksum gate set plus checksum error stops accumulation and pulses.
// - Power-down gate set plus supply low stops accumulation and pulses.
// - Polarity bit zero gives active-high interrupt pin, one active-low.
// - Continuous serial write mode is on while its control bit is zero.
// - Baud detection on first transaction only, or every one when set.
// - Sixteen writable 8-bit address slots, four per word, reset zero.
// - Checksum error is the status flag high on a bad parameter checksum.
// - Supply low is the status flag set below the power-down threshold.
module mmc_misc_control
  import mmc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  input  wire logic        wbWe,
  input  wire logic [9:0]  wbAdr,
  input  wire logic [3:0]  wbSel,
  input  wire logic [31:0] wbDatIn,
  output logic [31:0]      wbDatOut,
  output logic             wbAck,
  input  wire logic [8:0]  waveStoreCount,
  input  wire logic        checksumError,
  input  wire logic        supplyLowFlag,
  output logic             accumEnable,
  output logic             pulseOutEnable,
  input  wire logic        serialTransStart,
  output logic             continuousWriteEn,
  output logic             baudDetectNow,
  input  wire logic        blockReadReq,
  output logic [7:0]       regRdAddr,
  output logic             regRdStrobe,
  input  wire logic [31:0] regRdData,
  output logic [31:0]      blockData,
  output logic [3:0]       blockIndex,
  output logic             blockValid,
  input  wire logic        blockReady,
  output logic             blockBusy,
  output logic             irq,
  output logic             irqPin
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage.

  logic [4:0]   miscCtl;
  logic [8:0]   waveCount;
  logic [31:0]  blkWord [0:3];
  logic [`MMC_IRQ_BITS-1:0] irqStatus;
  logic [`MMC_IRQ_BITS-1:0] irqEnable;
  logic         checksumPrev;
  logic         supplyPrev;
  logic         firstTransDone;
  logic         blockDone;
  logic         gateActive;
  logic [`MMC_IRQ_BITS-1:0] irqEvents;
  logic [`MMC_IRQ_BITS-1:0] irqClearMask;
  logic [7:0]   regIdx;
  logic         busReq;
  logic         busWrite;
  logic         blkWrite;
  logic [31:0]  next_readData;
  logic [127:0] slotVector;

  // Replaces the byte lanes picked by sel and keeps the others.
  function automatic logic [31:0] laneMerge(input logic [31:0] oldVal,
                                            input logic [31:0] newVal,
                                            input logic [3:0]  sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    laneMerge = (oldVal & ~m) | (newVal & m);
  endfunction

  // True when an acknowledged write targets the given register index.
  function automatic logic writeHit(input logic       wr,
                                    input logic [7:0] have,
                                    input logic [7:0] want);
    writeHit = wr && (have == want);
  endfunction

  // Picks which of the four slot words an index in the slot range names.
  function automatic logic [1:0] slotWord(input logic [7:0] idx);
    slotWord = 2'(idx - `MMC_IDX_BLK0);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  // A request is answered one cycle after it appears; writes land with ack.
  // The two low address bits select a byte within a word and are ignored.
  assign regIdx   = wbAdr[9:2];
  assign busReq   = wbCyc & wbStb;
  assign busWrite = busReq & wbWe & wbAck;
  assign blkWrite = busWrite && regIdx >= `MMC_IDX_BLK0
                    && regIdx <= `MMC_IDX_BLK3;

  // Acknowledge pulses for one cycle and drops before the next request.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wbAck <= 1'b0;
    end else begin
      wbAck <= busReq & ~wbAck;
    end
  end

  // Read multiplexer; unmapped indices and the clear register read zero.
  always_comb begin
    next_readData = 32'h00000000;
    case (regIdx)
      `MMC_IDX_MISC: begin
        next_readData[`MMC_WAVE_CNT_MSB:`MMC_WAVE_CNT_LSB] = waveCount;
        next_readData[4:0] = miscCtl;
      end
      `MMC_IDX_BLK0: begin
        next_readData = blkWord[0];
      end
      `MMC_IDX_BLK1: begin
        next_readData = blkWord[1];
      end
      `MMC_IDX_BLK2: begin
        next_readData = blkWord[2];
      end
      `MMC_IDX_BLK3: begin
        next_readData = blkWord[3];
      end
      `MMC_IDX_IRQ_STATUS: begin
        next_readData[`MMC_IRQ_BITS-1:0] = irqStatus;
      end
      `MMC_IDX_IRQ_ENABLE: begin
        next_readData[`MMC_IRQ_BITS-1:0] = irqEnable;
      end
      default: begin
        next_readData = 32'h00000000;
      end
    endcase
  end

  // Read data is captured as the acknowledge is raised.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wbDatOut <= 32'h00000000;
    end else if (busReq & ~wbAck) begin
      wbDatOut <= next_readData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control word.

  // Only the five policy bits are writable; the rest read zero except the waveform count.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      miscCtl <= 5'(`MMC_MISC_RESET);
    end else if (writeHit(busWrite, regIdx, `MMC_IDX_MISC)) begin
      miscCtl <= 5'(laneMerge({27'h0, miscCtl}, wbDatIn, wbSel)
                    & `MMC_MISC_WMASK);
    end
  end

  // The waveform count follows the storage engine; bus writes never touch it.
  // Registering it keeps the read path free of the engine's timing.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waveCount <= 9'h000;
    end else begin
      waveCount <= waveStoreCount;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Block read address slots.

  // Four words of four slots each, byte lanes honoured.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        blkWord[i] <= `MMC_BLK_RESET;
      end
    end else if (blkWrite) begin
      blkWord[slotWord(regIdx)] <=
        laneMerge(blkWord[slotWord(regIdx)], wbDatIn, wbSel);
    end
  end

  // Slot 0 sits in the low byte of the first word, slot 15 at the top.
  assign slotVector = {blkWord[3], blkWord[2], blkWord[1], blkWord[0]};

  mmc_block_reader u_reader (
    .clk      (clk),
    .rst      (rst),
    .start    (blockReadReq),
    .slots    (slotVector),
    .rdAddr   (regRdAddr),
    .rdStrobe (regRdStrobe),
    .rdData   (regRdData),
    .outData  (blockData),
    .outIndex (blockIndex),
    .outValid (blockValid),
    .outReady (blockReady),
    .busy     (blockBusy),
    .done     (blockDone)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Energy and pulse gating.

  // Either gate with its condition present stops accumulation and pulses.
  // Both restart by themselves once the cause goes away.
  assign gateActive =
    (miscCtl[`MMC_BIT_CK_GATE] & checksumError) |
    (miscCtl[`MMC_BIT_PD_GATE] & supplyLowFlag);

  // Enables are registered so the datapath sees a clean level.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      accumEnable    <= 1'b1;
      pulseOutEnable <= 1'b1;
    end else begin
      accumEnable    <= ~gateActive;
      pulseOutEnable <= ~gateActive;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial port mode.

  // Continuous write is on while the control bit is clear.
  assign continuousWriteEn = ~miscCtl[`MMC_BIT_BURST_CTL];

  // Remembers that the first transaction after reset has been seen.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      firstTransDone <= 1'b0;
    end else if (serialTransStart) begin
      firstTransDone <= 1'b1;
    end
  end

  // Detection runs on the first transaction, or on all when adapting.
  assign baudDetectNow = serialTransStart &
    (miscCtl[`MMC_BIT_BAUD_ADAPT] | ~firstTransDone);

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts.

  // Rising edges of the two conditions and the end of a block read.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      checksumPrev <= 1'b0;
      supplyPrev   <= 1'b0;
    end else begin
      checksumPrev <= checksumError;
      supplyPrev   <= supplyLowFlag;
    end
  end

  // A flag already high out of reset counts as one rising edge.
  always_comb begin
    irqEvents = '0;
    irqEvents[`MMC_IRQ_CHECKSUM]   = checksumError & ~checksumPrev;
    irqEvents[`MMC_IRQ_SUPPLY_LOW] = supplyLowFlag & ~supplyPrev;
    irqEvents[`MMC_IRQ_BLOCK_DONE] = blockDone;
  end

  // A write to the clear register releases the bits written as one.
  assign irqClearMask = writeHit(busWrite, regIdx, `MMC_IDX_IRQ_CLEAR)
                        ? wbDatIn[`MMC_IRQ_BITS-1:0] : '0;

  // Sticky status; an event in the clearing cycle survives the clear.
  // A cause that stays present does not set its bit again after a clear.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqStatus <= `MMC_IRQ_RESET;
    end else begin
      irqStatus <= (irqStatus & ~irqClearMask) | irqEvents;
    end
  end

  // Enable register, same layout as status.
  // All enable bits sit in byte lane zero, so only its select matters.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqEnable <= `MMC_IRQ_RESET;
    end else if (writeHit(busWrite, regIdx, `MMC_IDX_IRQ_ENABLE)
                 && wbSel[0]) begin
      irqEnable <= wbDatIn[`MMC_IRQ_BITS-1:0];
    end
  end

  // Level interrupt, and the pin copy with selectable polarity.
  assign irq    = |(irqStatus & irqEnable);
  assign irqPin = irq ^ miscCtl[`MMC_BIT_IRQ_POL];

endmodule

// ==== verif/mmc_misc_control_asserts.sv ====
// Concurrent checks on the bus acknowledge, control word and block read ports.
`timescale 1ns/1ps
module mmc_misc_control_asserts (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wbCyc,
  input wire logic        wbStb,
  input wire logic        wbWe,
  input wire logic [9:0]  wbAdr,
  input wire logic [3:0]  wbSel,
  input wire logic [31:0] wbDatIn,
  input wire logic        wbAck,
  input wire logic        checksumError,
  input wire logic        supplyLowFlag,
  input wire logic        accumEnable,
  input wire logic        pulseOutEnable,
  input wire logic        serialTransStart,
  input wire logic        continuousWriteEn,
  input wire logic        baudDetectNow,
  input wire logic        blockReadReq,
  input wire logic        regRdStrobe,
  input wire logic [31:0] blockData,
  input wire logic [3:0]  blockIndex,
  input wire logic        blockValid,
  input wire logic        blockReady,
  input wire logic        blockBusy,
  input wire logic        irq,
  input wire logic        irqPin
);
  logic [4:0] ctl;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  // Shadow of the writable control bits, updated on the acknowledged write.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl <= 5'h00;
    end else if (wbAck && wbWe && wbAdr[9:2] == 8'h75 && wbSel[0]) begin
      ctl <= wbDatIn[4:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence ackPulse;
    wbAck ##1 !wbAck;
  endsequence
  sequence fetchSeq;
    regRdStrobe ##1 !regRdStrobe ##[1:2] blockValid;
  endsequence
  chk_ack_once: assert property (wbCyc && wbStb && !wbAck |=> ackPulse)
    else $error("bus acknowledge is not a single cycle after the request");
  chk_ck_gate: assert property (ctl[4] && checksumError
    |=> !accumEnable && !pulseOutEnable)
    else $error("checksum gate did not stop accumulation");
  chk_pd_gate: assert property (ctl[3] && supplyLowFlag
    |=> !pulseOutEnable && !accumEnable)
    else $error("supply gate did not stop the pulse output");
  chk_gate_open: assert property (!(ctl[4] && checksumError) &&
    !(ctl[3] && supplyLowFlag) |=> accumEnable && pulseOutEnable)
    else $error("accumulation stopped without a gated cause");
  chk_pin_pol: assert property (irqPin == (irq ^ ctl[2]))
    else $error("interrupt pin level does not follow polarity");
  chk_burst_mode: assert property (continuousWriteEn == !ctl[1])
    else $error("continuous write mode wrong for its control bit");
  chk_baud_every: assert property (serialTransStart && ctl[0]
    |-> baudDetectNow)
    else $error("baud detection missing with adaptation on");
  chk_baud_cause: assert property (baudDetectNow |-> serialTransStart)
    else $error("baud detection without a transaction start");
  chk_blk_start: assert property (blockReadReq && !blockBusy
    |=> fetchSeq)
    else $error("block read did not fetch and present slot zero");
  chk_valid_hold: assert property (blockValid && !blockReady |=>
    blockValid && $stable(blockData) && $stable(blockIndex))
    else $error("block word dropped before it was accepted");
endmodule
bind mmc_misc_control mmc_misc_control_asserts chk (.*);

// ==== verif/mmc_reg_file_model.sv ====
// Register file stand-in that answers the block reader's fetches.
`timescale 1ns/1ps
module mmc_reg_file_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  regRdAddr,
  input  wire logic        regRdStrobe,
  output logic      [31:0] regRdData
);
  logic        age;
  logic [7:0]  addr;
  logic [31:0] junk;
  // Track the fetch address and whether a strobe came one cycle ago.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      age  <= 1'b0;
      addr <= 8'h00;
      junk <= 32'h0f0f0f0f;
    end else begin
      age  <= regRdStrobe;
      junk <= ~junk + 32'h1;
      if (regRdStrobe) addr <= regRdAddr;
    end
  end
  // Data is good only in the cycle after the strobe; a late read sees churn.
  assign regRdData = age ? ({4{addr}} ^ 32'h5a5a5a5a) : junk;
endmodule

// ==== verif/mmc_misc_control_bench.sv ====
// Self-checking bench for the control word and block read slots.
`timescale 1ns/1ps
module mmc_misc_control_bench;
  logic        clk, rst, wbCyc, wbStb, wbWe, wbAck, blockReady, blockBusy;
  logic        checksumError, supplyLowFlag, accumEnable, pulseOutEnable;
  logic        serialTransStart, continuousWriteEn, baudDetectNow, irqPin;
  logic        blockReadReq, regRdStrobe, blockValid, irq, g;
  logic [9:0]  wbAdr;
  logic [3:0]  wbSel, blockIndex;
  logic [31:0] wbDatIn, wbDatOut, regRdData, blockData, w, seed;
  logic [31:0] wd[4];
  logic [8:0]  waveStoreCount;
  logic [7:0]  regRdAddr, k;
  logic [35:0] rdQ[$], bQ[$];
  int          error_cnt, cmp_count;
  mmc_misc_control DUT (.*);
  mmc_reg_file_model far (.*);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cmp(input string n, input logic [35:0] e,
                     input logic [35:0] v);
    cmp_count++;
    if (v !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // One classic bus cycle; a read notes its expected word for the monitor.
  task automatic wb(input logic r, input logic [7:0] i, input logic [31:0] d);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= !r;
    wbSel <= 4'hf;
    wbAdr <= {i, 2'b00};
    wbDatIn <= d;
    if (r) rdQ.push_back({4'h0, d});
    @(posedge clk);
    while (wbAck !== 1'b1) @(posedge clk);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic st(input logic e);
    serialTransStart <= 1'b1;
    @(posedge clk);
    cmp("baud", e, baudDetectNow);
    serialTransStart <= 1'b0;
    @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Clock, watchdog and the monitor that pops expected results.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #(5000 * 100);
    error_cnt++;
    test_done();
  end
  always @(posedge clk) begin
    if (wbAck === 1'b1 && !wbWe)
      cmp("read", rdQ.pop_front(), wbDatOut);
    if (blockValid === 1'b1 && blockReady)
      cmp("block", bQ.pop_front(), {blockIndex, blockData});
    blockReady <= ^rnd();
  end
  // Main sequence.
  initial begin
    {wbCyc, wbStb, wbWe, checksumError, supplyLowFlag} = 5'h00;
    {serialTransStart, blockReadReq, rst} = 3'h1;
    {wbAdr, wbDatIn, wbSel} = {10'h000, 32'h0, 4'hf};
    seed = 32'hb28b5643;
    w = rnd();
    waveStoreCount = w[8:0];
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    st(1'b1);
    st(1'b0);
    wb(1'b1, 8'h75, {7'h0, waveStoreCount, 16'h0});
    for (k = 0; k < 4; k++) wb(1'b1, 8'h79 + k, 32'h0);
    wb(1'b1, 8'h10, 32'h0);
    $display("reset values done");
    wb(1'b0, 8'h75, 32'h00000001);
    st(1'b1);
    st(1'b1);
    wb(1'b0, 8'h75, 32'h01ff001f);
    wb(1'b1, 8'h75, {7'h0, waveStoreCount, 16'h1f});
    cmp("cont", 1'b0, continuousWriteEn);
    wb(1'b0, 8'h75, 32'h0);
    cmp("cont", 1'b1, continuousWriteEn);
    $display("control word done");
    for (k = 0; k < 4; k++) begin
      wd[k] = rnd();
      wb(1'b0, 8'h79 + k, wd[k]);
    end
    for (k = 0; k < 4; k++) wb(1'b1, 8'h79 + k, wd[k]);
    for (k = 0; k < 16; k++)
      bQ.push_back({k[3:0], {4{wd[k[3:2]][8*k[1:0]+:8]}} ^ 32'h5a5a5a5a});
    blockReadReq <= 1'b1;
    @(posedge clk);
    blockReadReq <= 1'b0;
    @(posedge clk);
    while (blockBusy !== 1'b0) @(posedge clk);
    cmp("left", 0, bQ.size());
    wb(1'b1, 8'h80, 32'h4);
    $display("block read done");
    for (k = 0; k < 16; k++) begin
      wb(1'b0, 8'h75, {27'h0, k[3:2], 3'h0});
      {checksumError, supplyLowFlag} <= k[1:0];
      @(posedge clk);
      @(posedge clk);
      g = !((k[3] & k[1]) | (k[2] & k[0]));
      cmp("gate", {2{g}}, {accumEnable, pulseOutEnable});
    end
    $display("gating done");
    {checksumError, supplyLowFlag} <= 2'b00;
    for (k = 0; k < 2; k++) begin
      wb(1'b0, 8'h75, {29'h0, k[0], 2'h0});
      wb(1'b0, 8'h82, 32'h0);
      wb(1'b0, 8'h81, 32'h7);
      supplyLowFlag <= 1'b1;
      @(posedge clk);
      @(posedge clk);
      wb(1'b1, 8'h80, 32'h2);
      cmp("pin", {1'b0, k[0]}, {irq, irqPin});
      wb(1'b0, 8'h82, 32'h2);
      cmp("pin", {1'b1, ~k[0]}, {irq, irqPin});
      wb(1'b0, 8'h81, 32'h2);
      cmp("pin", {1'b0, k[0]}, {irq, irqPin});
      supplyLowFlag <= 1'b0;
    end
    $display("interrupt done");
    test_done();
  end
endmodule
